// ---- rtl/annunciator_regs.vh ----
// Constants for the front-panel annunciator: register offsets, fields, timing.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register port.
// Operation
// - In-service lamp lit when ready, no major
// - Fault-state lamp on not ready or major
// - One bank lamp, enable that bank only
// - Either bank editable regardless of active bank
// - Trip lamp lights and latches on trip
// - Trip lamp clears on reset after fault
// - Alarm lamp flashes for non-latching alarm
// - Latched alarm holds lamp steady until reset
// - Pickup lamp follows any pickup condition
// - Open lamp lit, colour selectable, default green
// - Closed lamp lit, colour selectable, default green
// - Maintenance lamp on maintenance element operation
// - Reset clears inactive latched conditions
// - Reset clears reclose shots and lockout
// - Trip, alarm, pickup override idle display
// - Idle timeout selects default display message
// - Minor error: fault-state lamp, in-service stays
// - Coil failure sets alarm and maintenance lamps
`ifndef ANNUNCIATOR_REGS_VH
`define ANNUNCIATOR_REGS_VH

// Register word offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_COLOUR 8'h04
`define REG_STATUS 8'h08
`define REG_EVENT 8'h0C
`define REG_MASK 8'h10
`define REG_TIMEOUT 8'h14
`define REG_EDIT 8'h18
`define REG_RECLOSE 8'h1C

// Control register fields
`define CTRL_READY 0
`define CTRL_BANK2 1
`define CTRL_RESET 2
`define CTRL_DEFAULT 2'h0

// Colour codes for breaker lamps
`define COL_OFF 2'h0
`define COL_RED 2'h1
`define COL_GREEN 2'h2
`define COL_ORANGE 2'h3

// Event bit positions
`define EV_TRIP 0
`define EV_ALARM 1
`define EV_PICKUP 2
`define EV_MAINT 3
`define EV_COIL 4
`define EV_MAJOR 5
`define EV_WIDTH 6

// Display selection
`define DISP_MENU 2'h0
`define DISP_TARGET 2'h1
`define DISP_DEFAULT 2'h2

// Timing
`define CLK_HZ 10000000
`define FLASH_HALF_MS 500
`define FLASH_HALF_CYC ((`CLK_HZ / 1000) * `FLASH_HALF_MS)
`define TIMEOUT_DEFAULT_S 16'h001E

`endif

// ---- rtl/flash_ticker.v ----
// Flash cadence generator: square wave of about 1 Hz.
// Assumes a free-running system clock and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module flash_ticker #(
    parameter HALF_CYCLES = 5000000,
    parameter SEC_CYCLES = 10000000
) (
    input wire ref_clk,
    input wire rst_n,
    output reg flashPhase,
    output reg secTick
);
    reg [23:0] halfCnt_q;
    reg [23:0] secCnt_q;

    // Half-period and one-second counters
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            halfCnt_q <= 24'h00_0000;
            secCnt_q <= 24'h00_0000;
            flashPhase <= 1'b0;
            secTick <= 1'b0;
        end else begin
            secTick <= 1'b0;
            if (halfCnt_q == HALF_CYCLES - 1) begin
                halfCnt_q <= 24'h00_0000;
                flashPhase <= ~flashPhase;
            end else begin
                halfCnt_q <= halfCnt_q + 24'h00_0001;
            end
            if (secCnt_q == SEC_CYCLES - 1) begin
                secCnt_q <= 24'h00_0000;
                secTick <= 1'b1;
            end else begin
                secCnt_q <= secCnt_q + 24'h00_0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/front_panel_status_annunciator.v ----
// Front-panel annunciator: lamp drive, latching, flashing, reset, display select.
// Assumes all inputs synchronous to ref_clk and a classic Wishbone master.
`timescale 1ns/1ns
`default_nettype none
`include "annunciator_regs.vh"
module front_panel_status_annunciator #(
    parameter NUM_ELEM = 8,
    parameter HALF_CYCLES = `FLASH_HALF_CYC,
    parameter SEC_CYCLES = `CLK_HZ
) (
    input wire ref_clk,
    input wire rst_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wb_err_o,
    // Status sources
    input wire majorError,
    input wire minorError,
    input wire [NUM_ELEM-1:0] elemAlarm,
    input wire [NUM_ELEM-1:0] elemAlarmLatched,
    input wire [NUM_ELEM-1:0] elemPickup,
    input wire faultActive,
    input wire tripCommand,
    input wire maintOperate,
    input wire tripCoilFail,
    input wire closeCoilFail,
    input wire breakerFailOp,
    input wire breakerOpen,
    input wire breakerClosed,
    input wire keypadReset,
    input wire breakerCtrlReset,
    input wire commsReset,
    input wire keyActivity,
    input wire [2:0] recloseShotsIn,
    input wire recloseLockoutIn,
    input wire [NUM_ELEM-1:0] outRelayDrive,
    // Lamps
    output reg operationalLamp,
    output reg faultStateLamp,
    output reg [1:0] bankLamp,
    output reg tripLamp,
    output reg alarmLamp,
    output reg pickupLamp,
    output reg maintLamp,
    output reg [1:0] openLampColour,
    output reg [1:0] shutLampColour,
    // Protection side
    output reg [1:0] bankEnable,
    output reg [NUM_ELEM-1:0] outRelayLatched,
    output reg coilAlarm,
    output reg breakerFailLatched,
    output reg recloseClear,
    output reg [1:0] displaySel,
    output wire irq
);
    reg [1:0] ctrl_q;
    reg [3:0] colour_q;
    reg [`EV_WIDTH-1:0] event_q;
    reg [`EV_WIDTH-1:0] mask_q;
    reg [15:0] timeout_q;
    reg [7:0] edit_q;
    reg tripLatch_q;
    reg [NUM_ELEM-1:0] alarmLatch_q;
    reg tripCoilLatch_q;
    reg closeCoilLatch_q;
    reg [15:0] idleCnt_q;
    reg [`EV_WIDTH-1:0] evSrcPrev_q;
    wire flashPhase;
    wire secTick;
    wire wbReq;
    wire wbWr;
    wire resetReq;
    wire anyAlarm;
    wire anyLatchedAlarm;
    wire anyPickup;
    wire coilNow;
    wire [`EV_WIDTH-1:0] evSrc;
    wire [`EV_WIDTH-1:0] evRise;
    wire [`EV_WIDTH-1:0] evClear;

    flash_ticker #(
        .HALF_CYCLES(HALF_CYCLES),
        .SEC_CYCLES(SEC_CYCLES)
    ) u_ticker (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flashPhase(flashPhase),
        .secTick(secTick)
    );

    // Bus decode and reset sources
    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wbWr = wbReq & wb_we_i & wb_sel_i[0];
    assign wb_err_o = 1'b0;
    assign resetReq = keypadReset | breakerCtrlReset | commsReset |
        (wbWr & (wb_adr_i == `REG_CTRL) & wb_dat_i[`CTRL_RESET]);
    assign anyAlarm = |elemAlarm;
    assign anyLatchedAlarm = |alarmLatch_q;
    assign anyPickup = |elemPickup;
    assign coilNow = tripCoilFail | closeCoilFail;
    assign evSrc = {majorError, coilNow, maintOperate, anyPickup,
        anyAlarm | anyLatchedAlarm, tripCommand & faultActive};
    assign evRise = evSrc & ~evSrcPrev_q;
    assign evClear = (wbWr && wb_adr_i == `REG_EVENT) ? wb_dat_i[`EV_WIDTH-1:0] :
        {`EV_WIDTH{1'b0}};
    assign irq = |(event_q & mask_q);

    // Software registers
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_DEFAULT;
            colour_q <= {`COL_GREEN, `COL_GREEN};
            mask_q <= {`EV_WIDTH{1'b0}};
            timeout_q <= `TIMEOUT_DEFAULT_S;
            edit_q <= 8'h00;
            event_q <= {`EV_WIDTH{1'b0}};
            evSrcPrev_q <= {`EV_WIDTH{1'b0}};
        end else begin
            evSrcPrev_q <= evSrc;
            event_q <= (event_q & ~evClear) | evRise; // Set wins over clear
            if (wbWr) begin
                case (wb_adr_i)
                    `REG_CTRL: ctrl_q <= wb_dat_i[1:0];
                    `REG_COLOUR: colour_q <= wb_dat_i[3:0];
                    `REG_MASK: mask_q <= wb_dat_i[`EV_WIDTH-1:0];
                    `REG_TIMEOUT: timeout_q <= wb_dat_i[15:0];
                    `REG_EDIT: edit_q <= wb_dat_i[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Bus answer: one cycle after request, unmapped reads zero
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h0000_0000;
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i)
                    `REG_CTRL: wb_dat_o <= {30'h0000_0000, ctrl_q};
                    `REG_COLOUR: wb_dat_o <= {28'h000_0000, colour_q};
                    `REG_STATUS: wb_dat_o <= {24'h00_0000, displaySel, maintLamp,
                        pickupLamp, alarmLamp, tripLamp, faultStateLamp,
                        operationalLamp};
                    `REG_EVENT: wb_dat_o <= {26'h000_0000, event_q};
                    `REG_MASK: wb_dat_o <= {26'h000_0000, mask_q};
                    `REG_TIMEOUT: wb_dat_o <= {16'h0000, timeout_q};
                    `REG_EDIT: wb_dat_o <= {24'h00_0000, edit_q};
                    `REG_RECLOSE: wb_dat_o <= {28'h000_0000, recloseLockoutIn,
                        recloseShotsIn};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Latched conditions: set wins, reset clears only inactive ones
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tripLatch_q <= 1'b0;
            alarmLatch_q <= {NUM_ELEM{1'b0}};
            tripCoilLatch_q <= 1'b0;
            closeCoilLatch_q <= 1'b0;
            breakerFailLatched <= 1'b0;
            outRelayLatched <= {NUM_ELEM{1'b0}};
            recloseClear <= 1'b0;
        end else begin
            recloseClear <= resetReq;
            if (tripCommand & faultActive) begin
                tripLatch_q <= 1'b1;
            end else if (resetReq && !faultActive) begin
                tripLatch_q <= 1'b0;
            end
            alarmLatch_q <= elemAlarmLatched |
                (resetReq ? {NUM_ELEM{1'b0}} : alarmLatch_q);
            tripCoilLatch_q <= tripCoilFail | (tripCoilLatch_q & ~resetReq);
            closeCoilLatch_q <= closeCoilFail | (closeCoilLatch_q & ~resetReq);
            breakerFailLatched <= breakerFailOp | (breakerFailLatched & ~resetReq);
            outRelayLatched <= outRelayDrive |
                (resetReq ? {NUM_ELEM{1'b0}} : outRelayLatched);
        end
    end

    // Idle timer for default display message
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            idleCnt_q <= 16'h0000;
        end else if (keyActivity) begin
            idleCnt_q <= 16'h0000;
        end else if (secTick && idleCnt_q != timeout_q) begin
            idleCnt_q <= idleCnt_q + 16'h0001;
        end
    end

    // Registered lamp and display drive
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            operationalLamp <= 1'b0;
            faultStateLamp <= 1'b1;
            bankLamp <= 2'h1;
            bankEnable <= 2'h1;
            tripLamp <= 1'b0;
            alarmLamp <= 1'b0;
            pickupLamp <= 1'b0;
            maintLamp <= 1'b0;
            openLampColour <= `COL_OFF;
            shutLampColour <= `COL_OFF;
            coilAlarm <= 1'b0;
            displaySel <= `DISP_MENU;
        end else begin
            operationalLamp <= ctrl_q[`CTRL_READY] & ~majorError;
            faultStateLamp <= ~ctrl_q[`CTRL_READY] | majorError | minorError;
            bankLamp <= ctrl_q[`CTRL_BANK2] ? 2'h2 : 2'h1;
            bankEnable <= ctrl_q[`CTRL_BANK2] ? 2'h2 : 2'h1;
            tripLamp <= tripLatch_q;
            coilAlarm <= tripCoilLatch_q | closeCoilLatch_q;
            // Steady for latched alarm or coil alarm, flash for alarm or major error, else off
            if (anyLatchedAlarm | tripCoilLatch_q | closeCoilLatch_q) begin
                alarmLamp <= 1'b1;
            end else if (anyAlarm | majorError) begin
                alarmLamp <= flashPhase;
            end else begin
                alarmLamp <= 1'b0;
            end
            pickupLamp <= anyPickup;
            maintLamp <= maintOperate | tripCoilLatch_q | closeCoilLatch_q;
            openLampColour <= breakerOpen ? colour_q[1:0] : `COL_OFF;
            shutLampColour <= breakerClosed ? colour_q[3:2] : `COL_OFF;
            if (tripLatch_q | anyAlarm | anyLatchedAlarm | anyPickup) begin
                displaySel <= `DISP_TARGET;
            end else if (idleCnt_q == timeout_q) begin
                displaySel <= `DISP_DEFAULT;
            end else begin
                displaySel <= `DISP_MENU;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/annunciator_assertions.sv ----
// Checker on the annunciator ports: lamp timing and latches.
// Assumes ref_clk and a synchronous active-low rst_n.
`timescale 1ns/1ns
`default_nettype none
module annunciator_assertions #(
    parameter NUM_ELEM = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic majorError,
    input wire logic [NUM_ELEM-1:0] elemPickup,
    input wire logic faultActive,
    input wire logic tripCommand,
    input wire logic maintOperate,
    input wire logic tripCoilFail,
    input wire logic keypadReset,
    input wire logic breakerCtrlReset,
    input wire logic commsReset,
    input wire logic operationalLamp,
    input wire logic faultStateLamp,
    input wire logic tripLamp,
    input wire logic pickupLamp,
    input wire logic maintLamp,
    input wire logic coilAlarm,
    input wire logic recloseClear
);
    // One domain, quiet in reset
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Lamps answer one or two edges after their cause
    a_oper_major_off: assert property (majorError |=> !operationalLamp)
        else $error("in-service lamp on with major error");
    a_fault_major_on: assert property (majorError |=> faultStateLamp)
        else $error("fault-state lamp off with major error");
    a_trip_lamp_set: assert property (tripCommand && faultActive |-> ##[1:2] tripLamp)
        else $error("trip lamp missed");
    a_trip_held_fault: assert property (tripLamp && faultActive && $past(faultActive)
        && $past(faultActive, 2) |=> tripLamp)
        else $error("trip lamp cleared during fault");
    a_pickup_follows: assert property (1'h1 |=> pickupLamp == |$past(elemPickup))
        else $error("pickup lamp wrong");
    a_maint_lamp_on: assert property (maintOperate |-> ##[1:2] maintLamp)
        else $error("maintenance lamp missed");
    a_reclose_clear: assert property (keypadReset || breakerCtrlReset || commsReset
        |=> recloseClear)
        else $error("reclose clear missed");
    a_coil_lamps_on: assert property (tripCoilFail |-> ##[1:2] (coilAlarm && maintLamp))
        else $error("coil alarm missed");
endmodule

bind front_panel_status_annunciator annunciator_assertions #(.NUM_ELEM(NUM_ELEM)) sva (.*);
`default_nettype wire

// ---- verification/panel_sources.sv ----
// Far-side source model: elements, self-test, breaker contacts, keypad.
// Assumes the bench steers these by name just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module panel_sources (
    output var logic majorError,
    output var logic minorError,
    output var logic [7:0] elemAlarm,
    output var logic [7:0] elemAlarmLatched,
    output var logic [7:0] elemPickup,
    output var logic faultActive,
    output var logic tripCommand,
    output var logic maintOperate,
    output var logic tripCoilFail,
    output var logic closeCoilFail,
    output var logic breakerFailOp,
    output var logic breakerOpen,
    output wire logic breakerClosed,
    output var logic keypadReset,
    output var logic breakerCtrlReset,
    output var logic commsReset,
    output var logic keyActivity,
    output var logic [2:0] recloseShotsIn,
    output var logic recloseLockoutIn,
    output var logic [7:0] outRelayDrive
);
    // The two breaker contacts always disagree
    assign breakerClosed = !breakerOpen;

    // Everything quiet at power-up
    initial begin
        {majorError, minorError, elemAlarm, elemAlarmLatched, elemPickup} = '0;
        {faultActive, tripCommand, maintOperate, tripCoilFail, closeCoilFail} = '0;
        {breakerFailOp, breakerOpen, keypadReset, breakerCtrlReset, commsReset} = '0;
        {keyActivity, recloseShotsIn, recloseLockoutIn, outRelayDrive} = '0;
    end
endmodule
`default_nettype wire

// ---- verification/tb_front_panel_status_annunciator.sv ----
// Annunciator bench: bus tasks, lamp scenarios, verdict.
// Assumes panel_sources on the far side and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "annunciator_regs.vh"
module tb_front_panel_status_annunciator;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] rd;
    int failures = 0;
    int n_tests = 0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, wb_err_o, majorError, minorError, faultActive, tripCommand, irq;
    wire maintOperate, tripCoilFail, closeCoilFail, breakerFailOp, breakerOpen;
    wire breakerClosed, keypadReset, breakerCtrlReset, commsReset, keyActivity;
    wire recloseLockoutIn, operationalLamp, faultStateLamp, tripLamp, alarmLamp;
    wire pickupLamp, maintLamp, coilAlarm, breakerFailLatched, recloseClear;
    wire [2:0] recloseShotsIn;
    wire [7:0] elemAlarm, elemAlarmLatched, elemPickup, outRelayDrive, outRelayLatched;
    wire [1:0] bankLamp, bankEnable, openLampColour, shutLampColour, displaySel;

    // Far side and block, flash and second counts shortened
    panel_sources src (.*);
    front_panel_status_annunciator #(.HALF_CYCLES(4), .SEC_CYCLES(10)) uut (.*);

    // 10 MHz clock
    always #50 ref_clk = !ref_clk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d, failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task settle;
        repeat (3) @(posedge ref_clk);
    endtask

    // One classic bus cycle, held until ack
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            failures++;
            wrap_up();
        end else begin
            rd = wb_dat_o;
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask

    // One-cycle reset request from source s
    task pulse(input int s);
        {src.commsReset, src.breakerCtrlReset, src.keypadReset} <= 3'h1 << s;
        @(posedge ref_clk);
        {src.commsReset, src.breakerCtrlReset, src.keypadReset} <= 3'h0;
        @(posedge ref_clk);
        chk(recloseClear, 1'h1);
        settle;
    endtask

    task t_ctrl;
        chk({faultStateLamp, bankLamp}, 3'h5);
        bus(1'h0, `REG_COLOUR, 32'h0000_0000);
        chk(rd, 32'h0000_000A);
        bus(1'h0, 8'h40, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(wb_err_o, 1'h0);
        bus(1'h1, `REG_CTRL, 32'h0000_0003);
        settle;
        chk({operationalLamp, faultStateLamp, bankLamp, bankEnable}, 6'h2A);
        src.minorError <= 1'h1;
        settle;
        chk({operationalLamp, faultStateLamp}, 2'h3);
        src.majorError <= 1'h1;
        settle;
        chk({operationalLamp, faultStateLamp}, 2'h1);
        src.majorError <= 1'h0;
        src.minorError <= 1'h0;
        bus(1'h1, `REG_EDIT, 32'h0000_0001);
        bus(1'h0, `REG_EDIT, 32'h0000_0000);
        chk(rd[0], 1'h1);
        chk({operationalLamp, faultStateLamp}, 2'h2);
        for (int c = 0; c < 4; c++) begin
            bus(1'h1, `REG_COLOUR, {28'h000_0000, c[1:0], c[1:0]});
            src.breakerOpen <= 1'h1;
            settle;
            chk({openLampColour, shutLampColour}, {c[1:0], 2'h0});
            src.breakerOpen <= 1'h0;
            settle;
            chk({openLampColour, shutLampColour}, {2'h0, c[1:0]});
        end
        $display("control test done");
    endtask

    task t_trip;
        for (int s = 0; s < 3; s++) begin
            src.faultActive <= 1'h1;
            src.tripCommand <= 1'h1;
            settle;
            src.tripCommand <= 1'h0;
            pulse(s);
            chk(tripLamp, 1'h1);
            src.faultActive <= 1'h0;
            settle;
            chk(tripLamp, 1'h1);
            pulse(s);
            chk(tripLamp, 1'h0);
        end
        $display("trip test done");
    endtask

    task t_alarm;
        int hi;
        hi = 0;
        src.elemAlarm <= 8'h10;
        settle;
        repeat (16) begin
            @(posedge ref_clk);
            hi += (alarmLamp === 1'h1);
        end
        chk(hi, 32'h0000_0008);
        src.elemAlarm <= 8'h00;
        src.outRelayDrive <= 8'h81;
        src.elemAlarmLatched <= 8'h02;
        src.tripCoilFail <= 1'h1;
        src.breakerFailOp <= 1'h1;
        settle;
        src.outRelayDrive <= 8'h01;
        src.elemAlarmLatched <= 8'h00;
        src.tripCoilFail <= 1'h0;
        src.breakerFailOp <= 1'h0;
        settle;
        chk({alarmLamp, maintLamp, coilAlarm, outRelayLatched}, 11'h781);
        chk(breakerFailLatched, 1'h1);
        repeat (10) begin
            @(posedge ref_clk);
            chk(alarmLamp, 1'h1);
        end
        pulse(0);
        chk({alarmLamp, coilAlarm, outRelayLatched}, 10'h001);
        chk(breakerFailLatched, 1'h0);
        $display("alarm test done");
    endtask

    task t_event;
        int n;
        src.outRelayDrive <= 8'h00;
        bus(1'h1, `REG_EVENT, 32'h0000_003F);
        bus(1'h1, `REG_MASK, 32'h0000_0000);
        src.elemPickup <= 8'h04;
        src.maintOperate <= 1'h1;
        settle;
        chk({pickupLamp, maintLamp, irq, displaySel}, 5'h19);
        bus(1'h0, `REG_EVENT, 32'h0000_0000);
        chk(rd, 32'h0000_000C);
        bus(1'h1, `REG_MASK, 32'h0000_0004);
        chk(irq, 1'h1);
        bus(1'h1, `REG_EVENT, 32'h0000_0004);
        chk(irq, 1'h0);
        src.elemPickup <= 8'h00;
        src.maintOperate <= 1'h0;
        bus(1'h1, `REG_TIMEOUT, 32'h0000_0002);
        src.keyActivity <= 1'h1;
        @(posedge ref_clk);
        src.keyActivity <= 1'h0;
        n = 0;
        while (displaySel !== `DISP_DEFAULT && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        chk({n > 8, n < 60, pickupLamp}, 3'h6);
        $display("event test done");
    endtask

    // Reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        t_ctrl;
        t_trip;
        t_alarm;
        t_event;
        wrap_up();
    end
endmodule
`default_nettype wire
